// ---- verilog/ethernet_autoneg_control.sv ----
// negotiation control: registers, break/negotiate/link sequencing
// assumes a management agent drives the register port synchronously and
// the receive paths report link, partner bursts and received code words
// What this block does
// - straps sampled at reset load advertisement [8:5]
// - two-strap variant maps strap pair to abilities
// - single-strap variant: half only or all four
// - advertisement register writes override straps anytime
// - send advertised abilities while negotiating
// - resolve 100 full, 100 half, 10 full, 10 half
// - forced mode takes speed and duplex bits
// - negotiation enabled ignores speed and duplex bits
// - status summary shows resolved speed once linked
// - fixed ability bits set, T4 clear
// - status shows complete, remote fault, link, preamble
// - advertisement defaults to strap value; software may clear bits
// - partner register stores base and next pages
// - parallel detect loads 0081h or 0021h
// - parallel detect sets bit 7 or 5, selector
// - expansion shows fault, next pages, page, able
// - both receivers monitor line for parallel detect
// - parallel detect leaves partner-able clear, complete set
// - fault when both links are good
// - restart bit or lost link renegotiates
// - restart stays silent for break time first; lost link goes straight to negotiate
// - negotiation gives up and retries after timeout
`timescale 1ns/1ns
module ethernet_autoneg_control #(
   parameter bit TWO_STRAP = 1'b1,
   parameter int BREAK_CYCLES = an_pkg::BREAK_CYC,
   parameter int NEG_CYCLES = an_pkg::NEG_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic adv_strap_sel0,
   input wire logic adv_strap_sel1,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [15:0] reg_rdata,
   input wire logic link10_good,
   input wire logic link100_good,
   input wire logic flp_seen,
   input wire logic rx_page_valid,
   input wire logic [15:0] rx_page_word,
   output logic flp_tx_en,
   output logic [15:0] tx_page_word,
   output logic tx_quiet,
   output logic rx10_monitor_en,
   output logic rx100_monitor_en,
   output logic op_speed100,
   output logic op_full_duplex,
   output logic op_link_up
);
   localparam int TW = $clog2(NEG_CYCLES + BREAK_CYCLES + 1);

   // refuse timer lengths the counter cannot serve
   if (BREAK_CYCLES < 1 || NEG_CYCLES < 1) begin : g_chk
      $error("timer lengths must be at least one cycle");
   end

   an_pkg::an_state_t state_q, state_d;
   logic [TW-1:0] timer_q;
   logic speed_q, an_en_q, duplex_q, restart_q;
   logic [3:0] adv_q;
   logic [15:0] lpa_q, base_q;
   logic lp_able_q, page_q, pdf_q, an_done_q;
   logic res_spd_q, res_fd_q;
   logic [15:0] rdata_q;
   logic op_spd_q, op_fd_q, op_link_q;
   logic [3:0] strap_abl, common_abl;
   logic found, pr_spd, pr_fd;
   logic bmc_wr, adv_wr, exp_rd, timer_done;
   logic an_ok, pd_ok, pd_fault, res_link, enter_up;

   // strap decoding for the advertisement reset value
   adv_strap_decode #(
      .TWO_STRAP(TWO_STRAP)
   ) u_strap (
      .adv_strap_sel0(adv_strap_sel0),
      .adv_strap_sel1(adv_strap_sel1),
      .strap_abl(strap_abl)
   );

   // best common mode from our advertisement and the partner base page
   assign common_abl = adv_q & base_q[an_pkg::ABL_HI:an_pkg::ABL_LO];
   an_priority u_prio (
      .common_abl(common_abl),
      .found(found),
      .speed100(pr_spd),
      .full(pr_fd)
   );

   // access strobes
   assign bmc_wr = reg_we && (reg_addr == an_pkg::REG_BMC);
   assign adv_wr = reg_we && (reg_addr == an_pkg::REG_ADV);
   assign exp_rd = reg_re && (reg_addr == an_pkg::REG_EXP);

   // completion conditions while negotiating
   assign an_ok = lp_able_q && found;
   assign pd_ok = !flp_seen && !lp_able_q && (link10_good ^ link100_good);
   assign pd_fault = !flp_seen && !lp_able_q && link10_good && link100_good;
   assign res_link = res_spd_q ? link100_good : link10_good;
   assign enter_up = (state_q == an_pkg::ST_NEG) && (state_d == an_pkg::ST_UP);

   // timer end depends on the phase being timed
   always_comb begin
      timer_done = 1'b0;
      if (state_q == an_pkg::ST_BREAK) begin
         timer_done = (timer_q == TW'(BREAK_CYCLES - 1));
      end else if (state_q == an_pkg::ST_NEG) begin
         timer_done = (timer_q == TW'(NEG_CYCLES - 1));
      end
   end

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         an_pkg::ST_BREAK: begin
            if (!an_en_q) begin
               state_d = an_pkg::ST_FORCE;
            end else if (timer_done && !restart_q) begin
               state_d = an_pkg::ST_NEG;
            end
         end
         an_pkg::ST_NEG: begin
            if (!an_en_q) begin
               state_d = an_pkg::ST_FORCE;
            end else if (restart_q) begin
               state_d = an_pkg::ST_BREAK;
            end else if (an_ok || pd_ok) begin
               state_d = an_pkg::ST_UP;
            end else if (timer_done) begin
               state_d = an_pkg::ST_BREAK;
            end
         end
         an_pkg::ST_UP: begin
            if (!an_en_q) begin
               state_d = an_pkg::ST_FORCE;
            end else if (restart_q) begin
               state_d = an_pkg::ST_BREAK;
            end else if (!res_link) begin
               state_d = an_pkg::ST_NEG;
            end
         end
         default: begin
            if (an_en_q) begin
               state_d = an_pkg::ST_BREAK;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= an_pkg::ST_NEG;
      end else begin
         state_q <= state_d;
      end
   end

   // phase timer restarts on every state change and on restart
   always_ff @(posedge clk) begin
      if (srst) begin
         timer_q <= '0;
      end else if (state_d != state_q || restart_q) begin
         timer_q <= '0;
      end else if (!timer_done) begin
         timer_q <= timer_q + TW'(1);
      end
   end

   // control register; writes land at any time
   always_ff @(posedge clk) begin
      if (srst) begin
         speed_q <= an_pkg::BMC_RESET[an_pkg::BMC_SPEED];
         an_en_q <= an_pkg::BMC_RESET[an_pkg::BMC_AN_EN];
         duplex_q <= an_pkg::BMC_RESET[an_pkg::BMC_DUPLEX];
      end else if (bmc_wr) begin
         speed_q <= reg_wdata[an_pkg::BMC_SPEED];
         an_en_q <= reg_wdata[an_pkg::BMC_AN_EN];
         duplex_q <= reg_wdata[an_pkg::BMC_DUPLEX];
      end
   end

   // restart bit: set by write, self-clears once break phase runs
   always_ff @(posedge clk) begin
      if (srst) begin
         restart_q <= 1'b0;
      end else if (bmc_wr && reg_wdata[an_pkg::BMC_RESTART]) begin
         restart_q <= 1'b1;
      end else if (state_q == an_pkg::ST_BREAK || state_q == an_pkg::ST_FORCE) begin
         restart_q <= 1'b0;
      end
   end

   // advertisement: straps at reset, software may clear or set later
   always_ff @(posedge clk) begin
      if (srst) begin
         adv_q <= strap_abl;
      end else if (adv_wr) begin
         adv_q <= reg_wdata[an_pkg::ABL_HI:an_pkg::ABL_LO];
      end
   end

   // partner words: every received page, or the parallel detect value
   always_ff @(posedge clk) begin
      if (srst) begin
         lpa_q <= '0;
         base_q <= '0;
      end else if (state_q == an_pkg::ST_BREAK) begin
         lpa_q <= '0;
         base_q <= '0;
      end else if (state_q == an_pkg::ST_NEG && rx_page_valid) begin
         lpa_q <= rx_page_word;
         if (!lp_able_q) begin
            base_q <= rx_page_word;
         end
      end else if (enter_up && pd_ok) begin
         lpa_q <= link100_good ? an_pkg::LPA_PD100 : an_pkg::LPA_PD10;
         base_q <= '0;
      end
   end

   // partner-able flag stays low after parallel detect
   always_ff @(posedge clk) begin
      if (srst) begin
         lp_able_q <= 1'b0;
      end else if (state_q == an_pkg::ST_BREAK) begin
         lp_able_q <= 1'b0;
      end else if (state_q == an_pkg::ST_NEG && rx_page_valid) begin
         lp_able_q <= 1'b1;
      end
   end

   // page-received: cleared on expansion read, a new page wins
   always_ff @(posedge clk) begin
      if (srst) begin
         page_q <= 1'b0;
      end else if (state_q == an_pkg::ST_NEG && rx_page_valid) begin
         page_q <= 1'b1;
      end else if (exp_rd) begin
         page_q <= 1'b0;
      end
   end

   // parallel detect fault: cleared on expansion read, a new fault wins
   always_ff @(posedge clk) begin
      if (srst) begin
         pdf_q <= 1'b0;
      end else if (state_q == an_pkg::ST_NEG && pd_fault) begin
         pdf_q <= 1'b1;
      end else if (exp_rd) begin
         pdf_q <= 1'b0;
      end
   end

   // negotiation complete and resolved mode
   always_ff @(posedge clk) begin
      if (srst) begin
         an_done_q <= 1'b0;
         res_spd_q <= 1'b0;
         res_fd_q <= 1'b0;
      end else if (enter_up) begin
         an_done_q <= 1'b1;
         if (an_ok) begin
            res_spd_q <= pr_spd;
            res_fd_q <= pr_fd;
         end else begin
            res_spd_q <= link100_good;
            res_fd_q <= 1'b0;
         end
      end else if (state_d != an_pkg::ST_UP) begin
         an_done_q <= 1'b0;
      end
   end

   // operating mode: negotiated result or forced bits
   always_ff @(posedge clk) begin
      if (srst) begin
         op_spd_q <= 1'b0;
         op_fd_q <= 1'b0;
         op_link_q <= 1'b0;
      end else if (state_q == an_pkg::ST_FORCE) begin
         op_spd_q <= speed_q;
         op_fd_q <= duplex_q;
         op_link_q <= speed_q ? link100_good : link10_good;
      end else if (state_q == an_pkg::ST_UP) begin
         op_spd_q <= res_spd_q;
         op_fd_q <= res_fd_q;
         op_link_q <= res_link;
      end else begin
         op_link_q <= 1'b0;
      end
   end

   // registered read data; unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= '0;
      end else if (reg_re) begin
         rdata_q <= '0;
         if (reg_addr == an_pkg::REG_BMC) begin
            rdata_q[an_pkg::BMC_SPEED] <= speed_q;
            rdata_q[an_pkg::BMC_AN_EN] <= an_en_q;
            rdata_q[an_pkg::BMC_RESTART] <= restart_q;
            rdata_q[an_pkg::BMC_DUPLEX] <= duplex_q;
         end else if (reg_addr == an_pkg::REG_BMS) begin
            rdata_q <= an_pkg::BMS_FIXED;
            rdata_q[an_pkg::BMS_AN_DONE] <= an_done_q;
            rdata_q[an_pkg::BMS_RFAULT] <= base_q[an_pkg::WORD_RFAULT];
            rdata_q[an_pkg::BMS_LINK] <= op_link_q;
         end else if (reg_addr == an_pkg::REG_ADV) begin
            rdata_q[an_pkg::ABL_HI:an_pkg::ABL_LO] <= adv_q;
            rdata_q[an_pkg::SEL_HI:0] <= an_pkg::SELECTOR;
         end else if (reg_addr == an_pkg::REG_LPA) begin
            rdata_q <= lpa_q;
         end else if (reg_addr == an_pkg::REG_EXP) begin
            rdata_q[an_pkg::EXP_PDF] <= pdf_q;
            rdata_q[an_pkg::EXP_LP_NP] <= base_q[an_pkg::WORD_NP];
            rdata_q[an_pkg::EXP_NP] <= 1'b0;
            rdata_q[an_pkg::EXP_PAGE] <= page_q;
            rdata_q[an_pkg::EXP_LP_AN] <= lp_able_q;
         end else if (reg_addr == an_pkg::REG_STS) begin
            rdata_q[an_pkg::STS_LINK] <= op_link_q;
            rdata_q[an_pkg::STS_SPEED10] <= op_link_q && !op_spd_q;
            rdata_q[an_pkg::STS_DUPLEX] <= op_link_q && op_fd_q;
            rdata_q[an_pkg::STS_AN_DONE] <= an_done_q;
         end
      end
   end

   // link side: bursts carry the live advertisement word
   always_comb begin
      tx_page_word = '0;
      tx_page_word[an_pkg::ABL_HI:an_pkg::ABL_LO] = adv_q;
      tx_page_word[an_pkg::SEL_HI:0] = an_pkg::SELECTOR;
   end

   // bursts only while negotiating, silence during break
   assign flp_tx_en = (state_q == an_pkg::ST_NEG);
   assign tx_quiet = (state_q == an_pkg::ST_BREAK);
   assign rx10_monitor_en = (state_q == an_pkg::ST_NEG);
   assign rx100_monitor_en = (state_q == an_pkg::ST_NEG);

   // outputs
   assign reg_rdata = rdata_q;
   assign op_speed100 = op_spd_q;
   assign op_full_duplex = op_fd_q;
   assign op_link_up = op_link_q;
endmodule

// ---- verilog/an_pkg.sv ----
// constants shared by the negotiation control block and its helpers
// assumes a 25 MHz device clock and a 5-bit management register address
package an_pkg;
   // register addresses
   localparam logic [4:0] REG_BMC = 5'h00;
   localparam logic [4:0] REG_BMS = 5'h01;
   localparam logic [4:0] REG_ADV = 5'h04;
   localparam logic [4:0] REG_LPA = 5'h05;
   localparam logic [4:0] REG_EXP = 5'h06;
   localparam logic [4:0] REG_STS = 5'h10;
   // control register fields and reset value
   localparam int BMC_SPEED = 13;
   localparam int BMC_AN_EN = 12;
   localparam int BMC_RESTART = 9;
   localparam int BMC_DUPLEX = 8;
   localparam logic [15:0] BMC_RESET = 16'h3100;
   // status register: fixed ability bits, then live fields
   localparam logic [15:0] BMS_FIXED = 16'h7849;
   localparam int BMS_AN_DONE = 5;
   localparam int BMS_RFAULT = 4;
   localparam int BMS_LINK = 2;
   // advertisement and partner word layout
   localparam int ABL_LO = 5;
   localparam int ABL_HI = 8;
   localparam int SEL_HI = 4;
   localparam logic [4:0] SELECTOR = 5'h01;
   localparam int WORD_RFAULT = 13;
   localparam int WORD_NP = 15;
   localparam logic [15:0] LPA_PD100 = 16'h0081;
   localparam logic [15:0] LPA_PD10 = 16'h0021;
   // expansion register fields
   localparam int EXP_PDF = 4;
   localparam int EXP_LP_NP = 3;
   localparam int EXP_NP = 2;
   localparam int EXP_PAGE = 1;
   localparam int EXP_LP_AN = 0;
   // status summary fields
   localparam int STS_LINK = 0;
   localparam int STS_SPEED10 = 1;
   localparam int STS_DUPLEX = 2;
   localparam int STS_AN_DONE = 4;
   // ability nibble: 3=100 full, 2=100 half, 1=10 full, 0=10 half
   localparam logic [3:0] ABL_ALL = 4'hF;
   localparam logic [3:0] ABL_10 = 4'h3;
   localparam logic [3:0] ABL_100 = 4'hC;
   localparam logic [3:0] ABL_HALF = 4'h5;
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int BREAK_MS = 1500;
   localparam int NEG_MS = 3000;
   localparam int BREAK_CYC = BREAK_MS * (CLK_HZ / 1000);
   localparam int NEG_CYC = NEG_MS * (CLK_HZ / 1000);
   // negotiation states, gray along break, negotiate, up
   typedef enum logic [1:0] {
      ST_BREAK = 2'b00,
      ST_NEG = 2'b01,
      ST_UP = 2'b11,
      ST_FORCE = 2'b10
   } an_state_t;
endpackage

// ---- verilog/adv_strap_decode.sv ----
// maps advertisement strap levels onto the four ability bits
// assumes straps are static while reset is held
`timescale 1ns/1ns
module adv_strap_decode #(
   parameter bit TWO_STRAP = 1'b1
) (
   input wire logic adv_strap_sel0,
   input wire logic adv_strap_sel1,
   output logic [3:0] strap_abl
);
   // decode per variant
   always_comb begin
      if (TWO_STRAP) begin
         case ({adv_strap_sel1, adv_strap_sel0})
            2'b00: strap_abl = an_pkg::ABL_10;
            2'b01: strap_abl = an_pkg::ABL_100;
            2'b10: strap_abl = an_pkg::ABL_HALF;
            default: strap_abl = an_pkg::ABL_ALL;
         endcase
      end else begin
         strap_abl = adv_strap_sel0 ? an_pkg::ABL_ALL : an_pkg::ABL_HALF;
      end
   end
endmodule

// ---- verilog/an_priority.sv ----
// picks the best mode common to both ends
// assumes the common nibble is already masked by both sides
`timescale 1ns/1ns
module an_priority (
   input wire logic [3:0] common_abl,
   output logic found,
   output logic speed100,
   output logic full
);
   // highest priority first
   always_comb begin
      found = 1'b1;
      speed100 = 1'b0;
      full = 1'b0;
      if (common_abl[3]) begin
         speed100 = 1'b1;
         full = 1'b1;
      end else if (common_abl[2]) begin
         speed100 = 1'b1;
      end else if (common_abl[1]) begin
         full = 1'b1;
      end else if (!common_abl[0]) begin
         found = 1'b0;
      end
   end
endmodule

// ---- tb/ethernet_autoneg_control_properties.sv ----
// checker: port timing of the negotiation control block
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ns
module ethernet_autoneg_control_properties #(
   parameter bit TWO_STRAP = 1'b1,
   parameter int BREAK_CYCLES = 20
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic adv_strap_sel0,
   input wire logic adv_strap_sel1,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_we,
   input wire logic link10_good,
   input wire logic link100_good,
   input wire logic flp_tx_en,
   input wire logic [15:0] tx_page_word,
   input wire logic tx_quiet,
   input wire logic rx10_monitor_en,
   input wire logic rx100_monitor_en,
   input wire logic op_speed100,
   input wire logic op_full_duplex,
   input wire logic op_link_up
);
   logic [3:0] adv_q, strap_abl;
   logic ctl_wr, link_ok;
   logic [2:0] age_q;
   logic [15:0] qcnt_q, ctl_q, ctl_src;
   // reference strap decode, control source and link of the running speed
   assign strap_abl = (TWO_STRAP && !adv_strap_sel1) ? (adv_strap_sel0 ? 4'hC : 4'h3)
                                                     : (adv_strap_sel0 ? 4'hF : 4'h5);
   assign ctl_wr = reg_we && reg_addr == an_pkg::REG_BMC;
   assign ctl_src = srst ? an_pkg::BMC_RESET : reg_wdata;
   assign link_ok = op_speed100 ? link100_good : link10_good;
   // advertisement copy: straps during reset, then management writes
   always_ff @(posedge clk) begin
      if (srst) adv_q <= strap_abl;
      else if (reg_we && reg_addr == an_pkg::REG_ADV) adv_q <= reg_wdata[8:5];
   end
   // control copy and cycles since it was last written
   always_ff @(posedge clk) begin
      if (srst || ctl_wr) begin
         ctl_q <= ctl_src;
         age_q <= 3'h0;
      end else if (age_q != 3'h7) begin
         age_q <= age_q + 3'h1;
      end
   end
   // length of the current quiet phase
   always_ff @(posedge clk) begin
      if (srst || !tx_quiet) qcnt_q <= 16'h0000;
      else if (qcnt_q != 16'hFFFF) qcnt_q <= qcnt_q + 16'h0001;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   property p_restart_quiet;
      ctl_wr && reg_wdata[an_pkg::BMC_RESTART] && reg_wdata[an_pkg::BMC_AN_EN]
         |-> ##[1:2] tx_quiet;
   endproperty
   a_restart_quiet: assert property (p_restart_quiet) else $error("no quiet after restart");
   property p_quiet_silent;
      tx_quiet |-> !flp_tx_en;
   endproperty
   a_quiet_silent: assert property (p_quiet_silent) else $error("bursts while quiet");
   property p_break_hold;
      $rose(tx_quiet) |-> tx_quiet [*8];
   endproperty
   a_break_hold: assert property (p_break_hold) else $error("quiet phase cut short");
   property p_break_len;
      $fell(tx_quiet) |-> flp_tx_en && qcnt_q >= BREAK_CYCLES - 1 && qcnt_q <= BREAK_CYCLES + 1;
   endproperty
   a_break_len: assert property (p_break_len) else $error("quiet length or resume wrong");
   property p_monitor;
      flp_tx_en |-> rx10_monitor_en && rx100_monitor_en;
   endproperty
   a_monitor: assert property (p_monitor) else $error("receiver monitor off");
   property p_adv_word;
      tx_page_word[8:5] == adv_q && tx_page_word[4:0] == an_pkg::SELECTOR;
   endproperty
   a_adv_word: assert property (p_adv_word) else $error("sent word differs");
   property p_forced;
      age_q == 3'h7 && !ctl_q[an_pkg::BMC_AN_EN] && op_link_up |->
         op_speed100 == ctl_q[an_pkg::BMC_SPEED] && op_full_duplex == ctl_q[an_pkg::BMC_DUPLEX];
   endproperty
   a_forced: assert property (p_forced) else $error("forced mode not followed");
   property p_link_loss;
      op_link_up && !link_ok |-> ##[1:3] !op_link_up;
   endproperty
   a_link_loss: assert property (p_link_loss) else $error("link kept after loss");
   c_break: cover property ($rose(tx_quiet));
   c_up_fast: cover property ($rose(op_link_up) && op_speed100 && op_full_duplex);
   c_forced: cover property (age_q == 3'h7 && !ctl_q[an_pkg::BMC_AN_EN] && op_link_up);
endmodule
bind ethernet_autoneg_control ethernet_autoneg_control_properties #(
   .TWO_STRAP(TWO_STRAP),
   .BREAK_CYCLES(BREAK_CYCLES)
) i_ethernet_autoneg_control_properties (
   .clk, .srst, .adv_strap_sel0, .adv_strap_sel1, .reg_addr, .reg_wdata, .reg_we,
   .link10_good, .link100_good, .flp_tx_en, .tx_page_word, .tx_quiet, .rx10_monitor_en,
   .rx100_monitor_en, .op_speed100, .op_full_duplex, .op_link_up
);

// ---- tb/link_partner.sv ----
// partner model: remote end of the pair, negotiating or fixed speed
// assumes the device burst and quiet levels come straight from its state
`timescale 1ns/1ns
module link_partner (
   input wire logic clk,
   input wire logic an_able,
   input wire logic [3:0] abl,
   input wire logic rf,
   input wire logic pd10,
   input wire logic pd100,
   input wire logic drop,
   input wire logic [3:0] dly,
   input wire logic flp_tx_en,
   input wire logic tx_quiet,
   input wire logic [15:0] tx_page_word,
   output logic link10_good,
   output logic link100_good,
   output logic flp_seen,
   output logic rx_page_valid = 1'b0,
   output logic [15:0] rx_page_word = 16'h0000
);
   logic sent_q = 1'b0;
   logic [3:0] wait_q = 4'h0;
   logic talk, up, fast, fire;
   // bursts only while the device sends them; link only once it stops
   assign talk = an_able && flp_tx_en && !tx_quiet;
   assign up = an_able && !flp_tx_en && !tx_quiet && !drop;
   assign fast = |(abl[3:2] & tx_page_word[8:7]);
   assign fire = talk && !sent_q && wait_q == dly;
   assign flp_seen = talk;
   assign link100_good = an_able ? (up && fast) : pd100;
   assign link10_good = an_able ? (up && !fast) : pd10;
   // one base page per attempt after a chosen delay; idle word toggles
   always @(posedge clk) begin
      rx_page_valid <= fire;
      rx_page_word <= fire ? {2'h0, rf, 4'h0, abl, 5'h01} : ~rx_page_word;
      sent_q <= talk && (sent_q || fire);
      wait_q <= (talk && !sent_q && !fire) ? wait_q + 4'h1 : 4'h0;
   end
endmodule

// ---- tb/testbench.sv ----
// testbench: straps, management accesses and partner behaviour, self-checked
// assumes the checker is bound to the design and the partner model is built
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0, srst = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
   logic adv_strap_sel0 = 1'b1, adv_strap_sel1 = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic p_able = 1'b0, p_rf = 1'b0, p_pd10 = 1'b0, p_pd100 = 1'b0, p_drop = 1'b0;
   logic [3:0] p_abl = 4'h0, p_dly = 4'h0, a, b;
   logic [15:0] reg_rdata, rx_page_word, tx_page_word;
   logic link10_good, link100_good, flp_seen, rx_page_valid, flp_tx_en, tx_quiet;
   logic rx10_monitor_en, rx100_monitor_en, op_speed100, op_full_duplex, op_link_up;
   logic [1:0] r;
   int n_mismatch = 0;
   int n_tests = 0;
   // device with shortened break and negotiation timers, and its partner
   ethernet_autoneg_control #(.TWO_STRAP(1'b1), .BREAK_CYCLES(20), .NEG_CYCLES(60))
   i_ethernet_autoneg_control (.clk, .srst, .adv_strap_sel0, .adv_strap_sel1, .reg_addr,
      .reg_wdata, .reg_we, .reg_re, .reg_rdata, .link10_good, .link100_good, .flp_seen,
      .rx_page_valid, .rx_page_word, .flp_tx_en, .tx_page_word, .tx_quiet, .rx10_monitor_en,
      .rx100_monitor_en, .op_speed100, .op_full_duplex, .op_link_up);
   link_partner i_link_partner (.clk, .an_able(p_able), .abl(p_abl), .rf(p_rf), .pd10(p_pd10),
      .pd100(p_pd100), .drop(p_drop), .dly(p_dly), .flp_tx_en, .tx_quiet, .tx_page_word,
      .link10_good, .link100_good, .flp_seen, .rx_page_valid, .rx_page_word);
   // 25 MHz clock
   always #20 clk = ~clk;
   // verdict and end of run
   task automatic tally_and_finish;
      $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // compare tasks for register words and port levels
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp);
      chk_reg({15'h0000, got}, {15'h0000, exp});
   endtask
   // management accesses: one-cycle strobes launched after a rising edge
   task automatic wr(input logic [4:0] ad, input logic [15:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask
   task automatic rchk(input logic [4:0] ad, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_re <= 1'b0;
      @(negedge clk);
      chk_reg(reg_rdata & m, e);
   endtask
   // bounded wait on link (which=0) or bursts (which=1)
   task automatic wait_for(input bit which, input logic want);
      for (int i = 0; i < 400; i++) begin
         if ((which ? flp_tx_en : op_link_up) === want) return;
         @(negedge clk);
      end
      n_mismatch++;
      $display("[FAIL] t=%0t timeout got=%h exp=%h", $time, ~want, want);
      tally_and_finish();
   endtask
   task automatic set_partner(input logic ab, input logic [3:0] ab4, input logic f,
                              input logic l10, input logic l100, input logic dr);
      @(posedge clk);
      {p_able, p_abl, p_rf, p_pd10, p_pd100, p_drop} <= {ab, ab4, f, l10, l100, dr};
      p_dly <= 4'($urandom);
   endtask
   task automatic renegotiate;
      wr(an_pkg::REG_BMC, 16'h1200);
      repeat (3) @(negedge clk); // break has dropped any old link
      wait_for(1'b0, 1'b0);
      wait_for(1'b0, 1'b1);
   endtask
   // expected strap abilities and best common mode as {speed100, full}
   function automatic logic [3:0] strap_exp(input logic [1:0] s);
      return s[1] ? (s[0] ? 4'hF : 4'h5) : (s[0] ? 4'hC : 4'h3);
   endfunction
   function automatic logic [1:0] best(input logic [3:0] c);
      return c[3] ? 2'h3 : c[2] ? 2'h2 : c[1] ? 2'h1 : 2'h0;
   endfunction
   // main sequence
   initial begin
      void'($urandom(36825));
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         srst <= 1'b1;
         {adv_strap_sel1, adv_strap_sel0} <= 2'(s);
         repeat (5) @(posedge clk);
         srst <= 1'b0;
         rchk(an_pkg::REG_ADV, 16'hFFFF, {7'h00, strap_exp(2'(s)), 5'h01});
      end
      rchk(an_pkg::REG_BMC, 16'hFFFF, an_pkg::BMC_RESET);
      rchk(an_pkg::REG_BMS, 16'hFFCB, 16'h7849);
      rchk(5'h1F, 16'hFFFF, 16'h0000);
      $display("straps and reset values done");
      for (int i = 0; i < 8; i++) begin
         a = (i == 0) ? 4'hF : (i == 1) ? 4'h1 : 4'($urandom % 15 + 1);
         b = (i < 2) ? a : 4'($urandom);
         if ((a & b) == 4'h0) b = a;
         r = best(a & b);
         set_partner(1'b1, b, 1'($urandom), 1'b0, 1'b0, 1'b0);
         wr(an_pkg::REG_ADV, {7'h00, a, 5'h00});
         renegotiate();
         chk_pin(op_speed100, r[1]);
         chk_pin(op_full_duplex, r[0]);
         wr(an_pkg::REG_LPA, 16'h0000);
         rchk(an_pkg::REG_LPA, 16'hFFFF, {2'h0, p_rf, 4'h0, b, 5'h01});
         rchk(an_pkg::REG_STS, 16'h0017, {11'h000, 2'h2, r[0], ~r[1], 1'b1});
         rchk(an_pkg::REG_BMS, 16'h0034, {10'h000, 1'b1, p_rf, 4'h4});
         rchk(an_pkg::REG_EXP, 16'h000D, 16'h0001);
      end
      $display("negotiation done");
      set_partner(1'b1, p_abl, 1'b0, 1'b0, 1'b0, 1'b1);
      wait_for(1'b0, 1'b0);
      wait_for(1'b1, 1'b1);
      chk_pin(tx_quiet, 1'b0);
      $display("link loss done");
      for (int k = 0; k < 2; k++) begin
         set_partner(1'b0, 4'h0, 1'b0, k == 1, k == 0, 1'b0);
         renegotiate();
         chk_pin(op_speed100, k == 0);
         rchk(an_pkg::REG_LPA, 16'hFFFF, (k == 0) ? 16'h0081 : 16'h0021);
         rchk(an_pkg::REG_EXP, 16'h0001, 16'h0000);
         rchk(an_pkg::REG_BMS, 16'h0020, 16'h0020);
      end
      set_partner(1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0);
      wr(an_pkg::REG_BMC, 16'h1200);
      wait_for(1'b1, 1'b1);
      rchk(an_pkg::REG_EXP, 16'h0011, 16'h0010);
      chk_pin(op_link_up, 1'b0);
      wait_for(1'b1, 1'b0);
      chk_pin(tx_quiet, 1'b1);
      wait_for(1'b1, 1'b1);
      $display("parallel detection done");
      for (int f = 0; f < 4; f++) begin
         wr(an_pkg::REG_BMC, {2'h0, f[1], 4'h0, f[0], 8'h00});
         repeat (4) @(negedge clk);
         chk_pin(op_link_up, 1'b1);
         chk_pin(op_speed100, f[1]);
         chk_pin(op_full_duplex, f[0]);
      end
      $display("forced mode done");
      tally_and_finish();
   end
endmodule
